//--- hw/boot_seq_pkg.sv
// Types shared by the boot sequencer and its testbench.
package boot_seq_pkg;

  typedef enum {ST_SAMPLE, ST_EMU_WAIT, ST_COPY, ST_RUN} boot_state_e;

  typedef struct packed {
    logic little;
    logic bus_correct;
    logic rom_boot;
    logic rom_wide;
  } strap_s;

  typedef struct packed {
    logic en;
    logic [9:0] addr;
    logic [31:0] data;
  } mem_wr_s;

endpackage

//--- hw/boot_seq_regs.svh
// Register offsets, field positions, reset values and counts of the boot sequencer.
`ifndef BOOT_SEQ_REGS_SVH
`define BOOT_SEQ_REGS_SVH

`define BOOT_STATUS_OFS 4'h0
`define BOOT_CONTROL_OFS 4'h4
`define CTRL_RELEASE_BIT 0
`define STAT_LITTLE_BIT 0
`define STAT_CORRECT_BIT 1
`define STAT_ROMBOOT_BIT 2
`define STAT_ROMWIDE_BIT 3
`define STAT_STALL_BIT 4
`define STAT_RUN_BIT 5
`define STAT_CONFLICT_BIT 6
`define STAT_WORDS_LSB 16
`define IMAGE_BYTES 11'h400
`define IMAGE_WORDS 9'h100
`define BOOT_DEST_ADDR 10'h000
`define CPU_START_ADDR 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hw/boot_sequencer.sv
// Reset release, strap capture, emulation and ROM boot sequencing with an AXI4-Lite port.
// Functional notes
// - Byte order comes from the endian select strap, little endian when it is high.
// - With little endian and the correction strap high, bus data pass unchanged.
// - While RST_N is low the internal reset is asserted and all state takes reset values.
// - Internal reset release starts the processor with the configuration sampled then.
// - Exactly two boot modes exist, emulation boot and ROM boot.
// - Emulation boot stalls the CPU until the debug host releases it, then starts at 0.
// - ROM boot copies the 1K-byte image at the boot space start to address 0, CPU stalled.
// - Narrow ROM reads are packed into 32-bit words before they are written.
// - The copy runs as one single-frame block from the ROM to address 0.
// - When the copy is done the CPU leaves the stall and runs from address 0.
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_regs.svh"
module boot_sequencer
  import boot_seq_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic ENDIAN_SELECT_STRAP,
  input wire logic BUS_ENDIAN_CORRECTION_STRAP,
  input wire logic BOOT_ROM_MODE_STRAP,
  input wire logic ROM_WIDE_STRAP,
  output logic CORE_RESET_N,
  output logic CPU_STALL,
  output logic [31:0] CPU_START,
  output logic BIG_ENDIAN,
  output logic BUS_CORRECT_EN,
  output logic ROM_RD_REQ,
  output logic [9:0] ROM_ADDR,
  input wire logic ROM_RD_VALID,
  input wire logic [15:0] ROM_RD_DATA,
  output mem_wr_s MEM_WR,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == `BOOT_STATUS_OFS) || (a == `BOOT_CONTROL_OFS);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strap capture and sequencing state.

  boot_state_e state_r;
  boot_state_e state_nxt;
  strap_s straps_r;
  logic strap_valid_r;
  logic conflict_r;
  logic sw_release_r;
  logic [10:0] byte_cnt_r;
  logic [10:0] byte_nxt;
  logic [8:0] words_r;
  logic pk_valid;
  logic [31:0] pk_word;
  logic big_order;

  // The straps are caught one edge after release, never under the asynchronous reset.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      strap_valid_r <= 1'b0;
      straps_r <= '0;
    end
    else if (!strap_valid_r)
    begin
      strap_valid_r <= 1'b1;
      straps_r.little <= ENDIAN_SELECT_STRAP;
      straps_r.bus_correct <= BUS_ENDIAN_CORRECTION_STRAP;
      straps_r.rom_boot <= BOOT_ROM_MODE_STRAP;
      straps_r.rom_wide <= ROM_WIDE_STRAP;
    end
  end

  // A big endian setup with the correction strap high breaks the far-side contract.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      conflict_r <= 1'b0;
    else
      conflict_r <= strap_valid_r && !straps_r.little && straps_r.bus_correct;
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SAMPLE:
        if (!strap_valid_r)
          state_nxt = BOOT_ROM_MODE_STRAP ? ST_COPY : ST_EMU_WAIT;
      ST_EMU_WAIT:
        if (sw_release_r)
          state_nxt = ST_RUN;
      ST_COPY:
        if (words_r == `IMAGE_WORDS)
          state_nxt = ST_RUN;
      ST_RUN:
        state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_r <= ST_SAMPLE;
    else
      state_r <= state_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Processor controls.

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      CORE_RESET_N <= 1'b0;
      CPU_STALL <= 1'b1;
      CPU_START <= `CPU_START_ADDR;
      BIG_ENDIAN <= 1'b0;
      BUS_CORRECT_EN <= 1'b0;
    end
    else
    begin
      CORE_RESET_N <= strap_valid_r;
      CPU_STALL <= (state_nxt != ST_RUN);
      CPU_START <= `CPU_START_ADDR;
      BIG_ENDIAN <= strap_valid_r && !straps_r.little;
      BUS_CORRECT_EN <= big_order;
    end
  end

  // Only a big endian system with the correction strap low reorders the lanes.
  assign big_order = strap_valid_r && !straps_r.little && !straps_r.bus_correct;

  ////////////////////////////////////////////////////////////////////////////////
  // Boot ROM reader and block copy to address zero.

  always_comb
  begin
    byte_nxt = byte_cnt_r;
    if (ROM_RD_REQ && ROM_RD_VALID)
      byte_nxt = byte_cnt_r + (straps_r.rom_wide ? 11'd2 : 11'd1);
  end

  // One single-frame block: addresses climb from the boot space start and wrap back to 0 after the last read.
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      byte_cnt_r <= 11'h000;
      ROM_RD_REQ <= 1'b0;
      ROM_ADDR <= 10'h000;
    end
    else
    begin
      byte_cnt_r <= byte_nxt;
      ROM_ADDR <= byte_nxt[9:0];
      ROM_RD_REQ <= (state_nxt == ST_COPY) && (byte_nxt < `IMAGE_BYTES);
    end
  end

  narrow_word_packer u_packer
  (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .clear(state_r != ST_COPY),
    .lane_valid(ROM_RD_REQ && ROM_RD_VALID),
    .lane_data(ROM_RD_DATA),
    .wide(straps_r.rom_wide),
    .big_order(big_order),
    .word_valid(pk_valid),
    .word(pk_word)
  );

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      words_r <= 9'h000;
      MEM_WR <= '0;
    end
    else
    begin
      MEM_WR.en <= pk_valid;
      MEM_WR.addr <= `BOOT_DEST_ADDR + {words_r[7:0], 2'b00};
      MEM_WR.data <= pk_word;
      if (pk_valid)
        words_r <= words_r + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data may arrive in either order.

  logic aw_have_r;
  logic w_have_r;
  logic [3:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_go;
  logic [31:0] status_word;

  assign wr_go = aw_have_r && w_have_r && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `RESP_OKAY;
      sw_release_r <= 1'b0;
    end
    else
    begin
      sw_release_r <= 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_have_r <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        // The release is only honoured while emulation boot is waiting for it.
        sw_release_r <= (aw_addr_r == `BOOT_CONTROL_OFS) && w_strb_r[0]
          && w_data_r[`CTRL_RELEASE_BIT] && (state_r == ST_EMU_WAIT);
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`STAT_LITTLE_BIT] = straps_r.little;
    status_word[`STAT_CORRECT_BIT] = straps_r.bus_correct;
    status_word[`STAT_ROMBOOT_BIT] = straps_r.rom_boot;
    status_word[`STAT_ROMWIDE_BIT] = straps_r.rom_wide;
    status_word[`STAT_STALL_BIT] = CPU_STALL;
    status_word[`STAT_RUN_BIT] = (state_r == ST_RUN);
    status_word[`STAT_CONFLICT_BIT] = conflict_r;
    status_word[`STAT_WORDS_LSB +: 9] = words_r;
  end

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= (S_AXI_ARADDR == `BOOT_STATUS_OFS) ? status_word : 32'h0000_0000;
      S_AXI_RRESP <= mapped(S_AXI_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  strap_hold_a: assert property (strap_valid_r && $past(strap_valid_r) |-> $stable(straps_r))
    else $error("straps changed after sampling");
  endian_pick_a: assert property ($rose(strap_valid_r)
    |-> straps_r.little == $past(ENDIAN_SELECT_STRAP))
    else $error("endian strap not captured");
  core_release_a: assert property ($rose(strap_valid_r) |=> CORE_RESET_N)
    else $error("internal reset not released after sampling");
  reset_hold_a: assert property (!strap_valid_r |=> !CORE_RESET_N && CPU_STALL)
    else $error("core left reset too early");
  boot_pick_a: assert property ($rose(strap_valid_r)
    |-> state_r == (straps_r.rom_boot ? ST_COPY : ST_EMU_WAIT))
    else $error("wrong boot mode entered");
  emu_release_a: assert property (state_r == ST_EMU_WAIT && sw_release_r
    |=> !CPU_STALL && CPU_START == 32'h0000_0000)
    else $error("emulation release failed");
  emu_wait_a: assert property (state_r == ST_EMU_WAIT && !sw_release_r |=> CPU_STALL)
    else $error("cpu ran without release");
  copy_stall_a: assert property (state_r == ST_COPY |-> CPU_STALL)
    else $error("cpu ran during copy");
  dest_addr_a: assert property (MEM_WR.en
    |-> MEM_WR.addr == {words_r[7:0] - 8'h01, 2'b00})
    else $error("copy destination out of order");
  copy_done_a: assert property ($fell(CPU_STALL) && straps_r.rom_boot
    |-> words_r == 9'h100 && !ROM_RD_REQ)
    else $error("cpu released before copy finished");

endmodule // boot_sequencer
`default_nettype wire

//--- hw/narrow_word_packer.sv
// Packs 8-bit or 16-bit boot ROM reads into 32-bit instruction words.
`timescale 1ns/1ps
`default_nettype none
module narrow_word_packer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic lane_valid,
  input wire logic [15:0] lane_data,
  input wire logic wide,
  input wire logic big_order,
  output logic word_valid,
  output logic [31:0] word
);

  logic [1:0] part_r;
  logic [1:0] last_part;
  logic [4:0] pos;
  logic [31:0] ext;
  logic [31:0] word_nxt;

  // Big order puts the first part in the top lanes; little order leaves data as read.
  always_comb
  begin
    last_part = wide ? 2'd1 : 2'd3;
    if (wide)
      pos = big_order ? 5'd16 - {part_r[0], 4'b0000} : {part_r[0], 4'b0000};
    else
      pos = big_order ? 5'd24 - {part_r, 3'b000} : {part_r, 3'b000};
    ext = wide ? {16'h0000, lane_data} : {24'h00_0000, lane_data[7:0]};
    word_nxt = ((part_r == 2'd0) ? 32'h0000_0000 : word) | (ext << pos);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      part_r <= 2'd0;
      word <= 32'h0000_0000;
      word_valid <= 1'b0;
    end
    else
    begin
      word_valid <= lane_valid && !clear && (part_r == last_part);
      if (clear)
        part_r <= 2'd0;
      else if (lane_valid)
      begin
        word <= word_nxt;
        part_r <= (part_r == last_part) ? 2'd0 : part_r + 2'd1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  full_word_a: assert property (lane_valid && !clear && part_r == last_part |=> word_valid)
    else $error("packer missed a complete word");
  partial_word_a: assert property (lane_valid && part_r != last_part |=> !word_valid)
    else $error("packer emitted a partial word");
  little_lane_a: assert property (lane_valid && !clear && !big_order && part_r == 2'd0
    |=> word[7:0] == $past(lane_data[7:0]))
    else $error("little order first byte misplaced");

endmodule // narrow_word_packer
`default_nettype wire

//--- verification/boot_rom_model.sv
// Behavioural boot ROM that answers the sequencer's read handshake.
`timescale 1ns/1ps
`default_nettype none
module boot_rom_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic wide,
  input wire logic req,
  input wire logic [9:0] addr,
  output logic valid,
  output logic [15:0] data
);
  logic [1:0] wait_r;
  logic [15:0] last_r;

  // The image is stored in one fixed byte order, whatever byte order the system runs in.
  function automatic logic [7:0] rom_byte(input logic [9:0] a);
    rom_byte = a[7:0] ^ {4{a[9:8]}};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // A slow part answers every third cycle, so the sequencer must hold its request.
  assign valid = req && (!slow || wait_r == 2'h2);
  // Idle lines show the inverse of the last value, never a stale copy.
  assign data = !valid ? ~last_r :
                wide ? {rom_byte(addr + 10'h001), rom_byte(addr)} :
                {~rom_byte(addr), rom_byte(addr)};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_r <= 2'h0;
      last_r <= 16'h0000;
    end
    else
    begin
      wait_r <= (req && wait_r != 2'h2) ? wait_r + 2'h1 : 2'h0;
      if (valid)
        last_r <= data;
    end
  end
endmodule // boot_rom_model
`default_nettype wire

//--- verification/test_boot_sequencer.sv
// Self-checking bench for the boot sequencer with a behavioural boot ROM.
`timescale 1ns/1ps
`default_nettype none
`include "boot_seq_regs.svh"
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module test_boot_sequencer
  import boot_seq_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0;
  logic little = 1'b1, corr = 1'b1, rom = 1'b0, wide = 1'b0, slow = 1'b0;
  logic core_rst_n, stall, big, corr_en, rd_req, rd_valid;
  logic [31:0] start, rdata, rd_v;
  logic [9:0] rom_addr;
  logic [15:0] rd_data;
  mem_wr_s mem_wr;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [4:0] cfg = 5'h00;
  int mismatches = 0, comparisons = 0, wcount = 0;
  // Strap sets {little, correction, rom boot, wide, slow rom}; big endian ROM boots keep
  // correction low, and the last set, a big endian emulation boot, sets correction high on purpose to raise the conflict flag.
  logic [4:0] cfgs [6] = '{5'h1E, 5'h1D, 5'h04, 5'h07, 5'h18, 5'h08};

  boot_sequencer u_dut (.REF_CLK(clk), .RST_N(rst_n), .ENDIAN_SELECT_STRAP(little),
    .BUS_ENDIAN_CORRECTION_STRAP(corr), .BOOT_ROM_MODE_STRAP(rom), .ROM_WIDE_STRAP(wide),
    .CORE_RESET_N(core_rst_n), .CPU_STALL(stall), .CPU_START(start), .BIG_ENDIAN(big),
    .BUS_CORRECT_EN(corr_en), .ROM_RD_REQ(rd_req), .ROM_ADDR(rom_addr),
    .ROM_RD_VALID(rd_valid), .ROM_RD_DATA(rd_data), .MEM_WR(mem_wr),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  boot_rom_model u_rom (.clk(clk), .rst_n(rst_n), .slow(cfg[0]), .wide(cfg[1]),
    .req(rd_req), .addr(rom_addr), .valid(rd_valid), .data(rd_data));

  initial
  begin
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic timeout;
    mismatches++;
    results();
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      timeout();
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
      timeout();
  endtask

  // Packing follows the strap set captured at boot, not the flipped pins.
  function automatic logic [31:0] exp_word(input int idx);
    logic [9:0] a;
    logic [31:0] w;
    for (int k = 0; k < 4; k++)
    begin
      a = 10'(idx * 4 + k);
      w[8 * k +: 8] = a[7:0] ^ {4{a[9:8]}};
    end
    if (cfg[4] || cfg[3])
      exp_word = w;
    else if (cfg[1])
      exp_word = {w[15:0], w[31:16]};
    else
      exp_word = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  always @(posedge clk)
  begin
    if (mem_wr.en === 1'b1)
    begin
      `CHK(mem_wr.addr, 10'(wcount * 4));
      `CHK({stall, mem_wr.data}, {1'b1, exp_word(wcount)});
      wcount++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic boot(input logic [4:0] c);
    int n;
    cfg = c;
    rst_n <= 1'b0;
    {little, corr, rom, wide, slow} <= c;
    repeat (6) @(posedge clk);
    wcount = 0;
    `CHK({core_rst_n, stall, rd_req, mem_wr.en, big, corr_en}, 6'h10);
    `CHK({awready, wready, arready, bvalid, rvalid}, 5'h1C);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Flipped straps must not disturb a boot that has already sampled them.
    {little, corr, rom, wide} <= ~c[4:1];
    `CHK({core_rst_n, big, corr_en}, {1'b1, !c[4], !c[4] && !c[3]});
    rd(`BOOT_STATUS_OFS, rd_v, rsp);
    `CHK(rd_v[6:0], {!c[4] && c[3], 2'b01, c[1], c[2], c[3], c[4]});
    if (c[2])
    begin
      for (n = 0; n < 4000 && stall; n++)
        @(posedge clk);
      if (n == 4000)
        timeout();
      `CHK(wcount, 256);
    end
    else
    begin
      repeat (20) @(posedge clk);
      // Before the debug host releases the core, it stays stalled with the start vector already set.
      `CHK({stall, start}, {1'b1, `CPU_START_ADDR});
      wr(`BOOT_CONTROL_OFS, 32'h0000_0001, rsp);
      `CHK(rsp, `RESP_OKAY);
      for (n = 0; n < 4 && stall; n++)
        @(posedge clk);
      `CHK({stall, wcount}, {1'b0, 32'h0000_0000});
    end
    `CHK(start, `CPU_START_ADDR);
    rd(`BOOT_STATUS_OFS, rd_v, rsp);
    `CHK({rd_v[24:16], rd_v[5:4]}, {c[2] ? `IMAGE_WORDS : 9'h000, 2'b10});
  endtask

  initial
  begin
    for (int i = 0; i < 6; i++)
    begin
      boot(cfgs[i]);
      rd(4'h8, rd_v, rsp);
      `CHK({rsp, rd_v}, {`RESP_SLVERR, 32'h0000_0000});
      rd(`BOOT_CONTROL_OFS, rd_v, rsp);
      `CHK({rsp, rd_v}, {`RESP_OKAY, 32'h0000_0000});
      wr(4'h8, 32'h0000_0001, rsp);
      `CHK(rsp, `RESP_SLVERR);
    end
    results();
  end
endmodule // test_boot_sequencer
`default_nettype wire
